// File: rtl/isa_daq_pkg.sv
// Shared constants for the host channel interface of the acquisition adapter.
package isa_daq_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 512;
    localparam int FIFO_AW = 9;
    localparam int NSRC = 6;
    localparam logic [9:0] BASE_DEFAULT = 10'h220;
    // Register offsets inside the 32-byte window, taken from address lines 4..0.
    localparam logic [4:0] OFS_FIFO = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h02;
    localparam logic [4:0] OFS_CTRL = 5'h04;
    localparam logic [4:0] OFS_CLEAR = 5'h06;
    localparam logic [4:0] OFS_DMA = 5'h08;
    // Control register fields.
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_IRQ_LSB = 8;
    localparam int CTRL_DUAL = 11;
    localparam int CTRL_BIPOLAR = 12;
    localparam int CTRL_ADC_DMA = 13;
    localparam int CTRL_DAC_DMA = 14;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    // Clear register fields, bits 5..0 clear the pending sources.
    localparam int CLR_OVF = 7;
    localparam int CLR_FIFO = 8;
    // Status register fields, bits 5..0 show the pending sources.
    localparam int STAT_EMPTY = 8;
    localparam int STAT_FULL = 9;
    localparam int STAT_OVF = 10;
    // DMA channel register fields and reset value.
    localparam int DMA_A_LSB = 0;
    localparam int DMA_B_LSB = 4;
    localparam logic [15:0] DMA_RST = 16'h0065;
    // Interrupt source positions.
    localparam int SRC_FIFO = 0;
    localparam int SRC_ACQ = 1;
    localparam int SRC_TC = 2;
    localparam int SRC_DACNEED = 3;
    localparam int SRC_DACDONE = 4;
    localparam int SRC_UPDATE = 5;
    // Positions in the synchronised pin vector.
    localparam int PIN_W = 38;
    localparam int P_DACK = 0;
    localparam int P_TC = 8;
    localparam int P_IOW = 9;
    localparam int P_IOR = 10;
    localparam int P_AEN = 11;
    localparam int P_SA = 12;
    localparam int P_SD = 22;
endpackage : isa_daq_pkg

// File: rtl/adc_result_fifo.sv
// Converter result FIFO, 16 bits by 512 words in flip-flops.
`timescale 1ns/100ps
module adc_result_fifo (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic push,
    input wire logic [isa_daq_pkg::DATA_W-1:0] din,
    input wire logic pop,
    input wire logic flush,
    output logic [isa_daq_pkg::DATA_W-1:0] dout,
    output logic empty,
    output logic full
);
    typedef struct packed {
        logic [isa_daq_pkg::FIFO_DEPTH-1:0][isa_daq_pkg::DATA_W-1:0] mem;
        logic [isa_daq_pkg::FIFO_AW-1:0] wr;
        logic [isa_daq_pkg::FIFO_AW-1:0] rd;
        logic [isa_daq_pkg::FIFO_AW:0] count;
    } fifo_t;
    fifo_t q, next_q;
    logic do_push, do_pop;

    // A push into a full FIFO is dropped; the parent flags that as overflow.
    always_comb begin
        next_q = q;
        do_push = push && !full;
        do_pop = pop && !empty;
        if (do_push) begin
            next_q.mem[q.wr] = din;
            next_q.wr = q.wr + 1'b1;
        end
        if (do_pop) begin
            next_q.rd = q.rd + 1'b1;
        end
        next_q.count = q.count + {{isa_daq_pkg::FIFO_AW{1'b0}}, do_push} - {{isa_daq_pkg::FIFO_AW{1'b0}}, do_pop};
        if (flush) begin
            next_q.wr = '0;
            next_q.rd = '0;
            next_q.count = '0;
        end
    end

    // Storage is not reset, only the pointers and the count are.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q.wr <= '0;
            q.rd <= '0;
            q.count <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign dout = q.mem[q.rd];
    assign empty = (q.count == '0);
    assign full = (q.count == 10'(isa_daq_pkg::FIFO_DEPTH));

    // Occupancy never exceeds the 512-word depth.
    fifo_depth_a: assert property (@(posedge sys_clk) disable iff (reset) q.count <= 10'(isa_daq_pkg::FIFO_DEPTH)) // [RL16]
        else $error("result fifo count above depth");
    // A lone accepted push raises the count by one.
    fifo_store_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL17]
        push && !full && !pop && !flush |=> q.count == $past(q.count) + 10'h001)
        else $error("accepted push did not raise count");
endmodule : adc_result_fifo

// File: rtl/isa_daq_host_if.sv
// Host channel interface: decode, transfer cycles, interrupts, DMA and result FIFO.
`timescale 1ns/100ps
// Functional notes
// RL1: Decode ten address lines, base 000..3FF.
// RL2: Board select when lines 9..5 match base.
// RL3: Lines 4..0 select individual registers.
// RL4: Default base 220h, window 220h..23Fh.
// RL5: Accept 8/16-bit cycles, strobes from channel.
// RL6: Answer selected, ready and transfer width.
// RL7: Host uses each register's own width.
// RL8: Interrupt line driven tristate, shareable.
// RL9: Interrupt line chosen among eight lines.
// RL10: Six sources, each enabled and cleared alone.
// RL11: FIFO service and acquisition done sources.
// RL12: Terminal count, DAC need, done, update edge.
// RL13: DMA request on result ready, DAC need.
// RL14: 16-bit DMA on host channels 5-7; the code accepts any channel 0-7.
// RL15: Single or dual channel DMA, software chosen.
// RL16: Result FIFO is 16 by 512.
// RL17: Each conversion result pushed into FIFO.
// RL18: Push into full FIFO flags overflow.
// RL19: Non-empty FIFO may request DMA or interrupt.
// RL20: Unipolar straight binary, bipolar two's complement.
// RL21: Sources stay pending until cleared by software.
// RL22: Overflow flag held until explicitly cleared.
module isa_daq_host_if #(
    parameter logic [9:0] BASE_ADDR = isa_daq_pkg::BASE_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [9:0] isa_sa,
    input wire logic [15:0] isa_sd_in,
    output logic [15:0] isa_sd_out,
    output logic isa_sd_oe,
    input wire logic isa_aen,
    input wire logic isa_ior_n,
    input wire logic isa_iow_n,
    input wire logic isa_tc,
    input wire logic [7:0] isa_dack_n,
    output logic [7:0] isa_drq,
    output logic isa_cs16_n,
    output logic isa_cs16_oe,
    output logic isa_chrdy,
    output logic isa_chrdy_oe,
    output logic [7:0] irq_req,
    output logic [7:0] irq_oe,
    input wire logic adc_valid,
    input wire logic [15:0] adc_data,
    input wire logic acq_done,
    input wire logic dac_fifo_need,
    input wire logic dac_done,
    input wire logic dac_update,
    output logic dac_wr,
    output logic [15:0] dac_wdata
);
    typedef struct packed {
        logic [isa_daq_pkg::PIN_W-1:0] s1;
        logic [isa_daq_pkg::PIN_W-1:0] s2;
        logic [isa_daq_pkg::PIN_W-1:0] s3;
        logic [isa_daq_pkg::PIN_W-1:0] pin;
        logic [15:0] ctrl;
        logic [15:0] dma_cfg;
        logic [isa_daq_pkg::NSRC-1:0] pend;
        logic ovf;
        logic upd_prev;
        logic tc_prev;
        logic rd_pop;
        logic wr_pend;
        logic wr_dac;
        logic [4:0] wadr;
        logic [15:0] wdata;
        logic [15:0] sd_out;
        logic sd_oe;
        logic cs16_n;
        logic cs16_oe;
        logic chrdy;
        logic chrdy_oe;
        logic [7:0] irq_req;
        logic [7:0] irq_oe;
        logic [7:0] drq;
        logic dac_wr;
        logic [15:0] dac_wdata;
    } state_t;

    state_t q, next_q;

    // True when the register offset matches the given offset; mapped checks it against every mapped register.
    function automatic logic reg_hit(input logic [4:0] adr, input logic [4:0] ofs);
        reg_hit = (adr == ofs);
    endfunction : reg_hit

    function automatic logic mapped(input logic [4:0] adr);
        mapped = reg_hit(adr, isa_daq_pkg::OFS_FIFO) || reg_hit(adr, isa_daq_pkg::OFS_STATUS)
            || reg_hit(adr, isa_daq_pkg::OFS_CTRL) || reg_hit(adr, isa_daq_pkg::OFS_CLEAR)
            || reg_hit(adr, isa_daq_pkg::OFS_DMA);
    endfunction : mapped

    logic [15:0] fifo_dout, fifo_din;
    logic fifo_empty, fifo_full, fifo_pop, fifo_flush;
    logic [9:0] addr;
    logic [15:0] sdata;
    logic aen, ior_l, iow_l, tc, sel, any_hit, dual, a_is_adc;
    logic [2:0] ch_a, ch_b;
    logic dack_a, dack_b, adc_ack, dac_ack, req_a, req_b, ovf_event, active;
    logic [isa_daq_pkg::NSRC-1:0] ev, clr;
    logic [15:0] rdata;

    // Result FIFO; the converter push is never held off, so a full FIFO loses the new word.
    adc_result_fifo u_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .push(adc_valid), // [RL17]
        .din(fifo_din),
        .pop(fifo_pop),
        .flush(fifo_flush),
        .dout(fifo_dout),
        .empty(fifo_empty),
        .full(fifo_full)
    );

    // Bipolar results arrive offset binary; flipping the top bit yields two's complement.
    assign fifo_din = {adc_data[15] ^ q.ctrl[isa_daq_pkg::CTRL_BIPOLAR], adc_data[14:0]}; // [RL20]

    always_comb begin
        next_q = q;
        // Three-stage pin synchroniser; a bit changes once stages two and three agree.
        next_q.s1 = {isa_sd_in, isa_sa, isa_aen, isa_ior_n, isa_iow_n, isa_tc, isa_dack_n};
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.pin = ((q.s2 ~^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.pin);

        addr = q.pin[isa_daq_pkg::P_SA +: 10];
        sdata = q.pin[isa_daq_pkg::P_SD +: 16];
        aen = q.pin[isa_daq_pkg::P_AEN];
        ior_l = !q.pin[isa_daq_pkg::P_IOR]; // [RL5]
        iow_l = !q.pin[isa_daq_pkg::P_IOW]; // [RL5]
        tc = q.pin[isa_daq_pkg::P_TC];

        // Only ten lines take part; lines 9..5 select the board, 4..0 the register.
        sel = !aen && (addr[9:5] == BASE_ADDR[9:5]); // [RL1] [RL2] [RL4]
        any_hit = sel && mapped(addr[4:0]); // [RL3]

        // DMA channel routing; single mode uses channel A for the result stream when its DMA is enabled, else the DAC stream.
        dual = q.ctrl[isa_daq_pkg::CTRL_DUAL]; // [RL15]
        ch_a = q.dma_cfg[isa_daq_pkg::DMA_A_LSB +: 3]; // [RL14]
        ch_b = q.dma_cfg[isa_daq_pkg::DMA_B_LSB +: 3];
        a_is_adc = dual || q.ctrl[isa_daq_pkg::CTRL_ADC_DMA];
        dack_a = !q.pin[isa_daq_pkg::P_DACK + 32'(ch_a)];
        dack_b = dual && !q.pin[isa_daq_pkg::P_DACK + 32'(ch_b)];
        adc_ack = dack_a && a_is_adc;
        dac_ack = (dack_a && !a_is_adc) || dack_b;
        req_a = a_is_adc ? (!fifo_empty && q.ctrl[isa_daq_pkg::CTRL_ADC_DMA])
                         : (dac_fifo_need && q.ctrl[isa_daq_pkg::CTRL_DAC_DMA]); // [RL13] [RL19]
        req_b = dual && dac_fifo_need && q.ctrl[isa_daq_pkg::CTRL_DAC_DMA]; // [RL13]
        next_q.drq = (req_a ? (8'h01 << ch_a) : 8'h00) | (req_b ? (8'h01 << ch_b) : 8'h00);

        // Read data mux; unmapped offsets read as zero.
        rdata = 16'h0000;
        if (reg_hit(addr[4:0], isa_daq_pkg::OFS_FIFO)) begin
            rdata = fifo_dout;
        end else if (reg_hit(addr[4:0], isa_daq_pkg::OFS_STATUS)) begin
            rdata[isa_daq_pkg::NSRC-1:0] = q.pend;
            rdata[isa_daq_pkg::STAT_EMPTY] = fifo_empty;
            rdata[isa_daq_pkg::STAT_FULL] = fifo_full;
            rdata[isa_daq_pkg::STAT_OVF] = q.ovf;
        end else if (reg_hit(addr[4:0], isa_daq_pkg::OFS_CTRL)) begin
            rdata = q.ctrl;
        end else if (reg_hit(addr[4:0], isa_daq_pkg::OFS_DMA)) begin
            rdata = q.dma_cfg;
        end

        // Drive the data bus for the whole read strobe, from registers or the FIFO under DMA.
        next_q.sd_oe = 1'b0;
        next_q.sd_out = 16'h0000;
        if (ior_l && adc_ack) begin
            next_q.sd_oe = 1'b1;
            next_q.sd_out = fifo_dout;
        end else if (ior_l && sel) begin
            next_q.sd_oe = 1'b1;
            next_q.sd_out = rdata;
        end

        // Channel answers: 16-bit width while a mapped register is addressed, ready only during its strobe.
        next_q.cs16_n = 1'b0; // [RL6]
        next_q.cs16_oe = any_hit; // [RL6]
        next_q.chrdy = 1'b1;
        next_q.chrdy_oe = any_hit && (ior_l || iow_l); // [RL6]

        // The FIFO pops at the end of the read so the word stays put during the strobe.
        fifo_pop = 1'b0;
        if (ior_l) begin
            next_q.rd_pop = adc_ack || (sel && reg_hit(addr[4:0], isa_daq_pkg::OFS_FIFO));
        end else begin
            fifo_pop = q.rd_pop;
            next_q.rd_pop = 1'b0;
        end

        // Writes are captured while the strobe is low and acted on at its release.
        clr = '0;
        fifo_flush = 1'b0;
        next_q.dac_wr = 1'b0;
        if (iow_l) begin
            if (dac_ack) begin
                next_q.wr_dac = 1'b1;
                next_q.wdata = sdata;
            end else if (any_hit) begin
                next_q.wr_pend = 1'b1;
                next_q.wadr = addr[4:0];
                next_q.wdata = sdata;
            end
        end else begin
            next_q.wr_pend = 1'b0;
            next_q.wr_dac = 1'b0;
            if (q.wr_dac) begin
                next_q.dac_wr = 1'b1;
                next_q.dac_wdata = q.wdata;
            end
            if (q.wr_pend) begin
                if (reg_hit(q.wadr, isa_daq_pkg::OFS_CTRL)) begin
                    next_q.ctrl = q.wdata;
                end
                if (reg_hit(q.wadr, isa_daq_pkg::OFS_DMA)) begin
                    next_q.dma_cfg = q.wdata;
                end
                if (reg_hit(q.wadr, isa_daq_pkg::OFS_CLEAR)) begin
                    clr = q.wdata[isa_daq_pkg::NSRC-1:0]; // [RL10]
                    fifo_flush = q.wdata[isa_daq_pkg::CLR_FIFO];
                end
            end
        end

        // Interrupt events; a level source simply re-sets its bit each cycle it holds.
        ovf_event = adc_valid && fifo_full; // [RL18]
        ev = '0;
        ev[isa_daq_pkg::SRC_FIFO] = !fifo_empty; // [RL11] [RL19]
        ev[isa_daq_pkg::SRC_ACQ] = acq_done || ovf_event; // [RL11]
        ev[isa_daq_pkg::SRC_TC] = tc && !q.tc_prev && (dack_a || dack_b); // [RL12]
        ev[isa_daq_pkg::SRC_DACNEED] = dac_fifo_need; // [RL12]
        ev[isa_daq_pkg::SRC_DACDONE] = dac_done; // [RL12]
        ev[isa_daq_pkg::SRC_UPDATE] = q.upd_prev && !dac_update; // [RL12]
        next_q.tc_prev = tc;
        next_q.upd_prev = dac_update;
        // Set beats clear so an event in the clearing cycle survives.
        next_q.pend = (q.pend & ~clr) | ev; // [RL10] [RL21]
        next_q.ovf = (q.ovf && !(q.wr_pend && !iow_l && reg_hit(q.wadr, isa_daq_pkg::OFS_CLEAR)
                      && q.wdata[isa_daq_pkg::CLR_OVF])) || ovf_event; // [RL18] [RL22]

        // One selected line is driven high while any enabled source is pending, else released.
        // The new enables and line choice are used so the line never lags a control write.
        active = |(next_q.pend & next_q.ctrl[isa_daq_pkg::CTRL_EN_LSB +: isa_daq_pkg::NSRC]); // [RL21]
        next_q.irq_req = active ? (8'h01 << next_q.ctrl[isa_daq_pkg::CTRL_IRQ_LSB +: 3]) : 8'h00; // [RL9]
        next_q.irq_oe = next_q.irq_req; // [RL8]
    end

    // Single register stage for all state; constants only under reset.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            q <= '0;
            q.s1 <= '1;
            q.s2 <= '1;
            q.s3 <= '1;
            q.pin <= '1;
            q.ctrl <= isa_daq_pkg::CTRL_RST;
            q.dma_cfg <= isa_daq_pkg::DMA_RST;
            q.cs16_n <= 1'b1;
            q.chrdy <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign isa_sd_out = q.sd_out;
    assign isa_sd_oe = q.sd_oe;
    assign isa_drq = q.drq;
    assign isa_cs16_n = q.cs16_n;
    assign isa_cs16_oe = q.cs16_oe;
    assign isa_chrdy = q.chrdy;
    assign isa_chrdy_oe = q.chrdy_oe;
    assign irq_req = q.irq_req;
    assign irq_oe = q.irq_oe;
    assign dac_wr = q.dac_wr;
    assign dac_wdata = q.dac_wdata;

    // Overflow stays set until an explicit clear write completes.
    ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL22]
        q.ovf && !(q.wr_pend && !iow_l && reg_hit(q.wadr, isa_daq_pkg::OFS_CLEAR)) |=> q.ovf)
        else $error("overflow flag dropped without clear");
    // A result arriving at a full FIFO raises overflow next cycle.
    ovf_set_a: assert property (@(posedge sys_clk) disable iff (reset) adc_valid && fifo_full |=> q.ovf) // [RL18]
        else $error("overflow not flagged on full push");
    // At most one request line is driven at a time.
    irq_onehot_a: assert property (@(posedge sys_clk) disable iff (reset) $onehot0(irq_oe)) // [RL9]
        else $error("more than one request line driven");
    // The request line is driven only with an enabled pending source behind it.
    irq_cause_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL21]
        (irq_oe != 8'h00) |-> (q.pend & q.ctrl[5:0]) != 6'h00)
        else $error("request line driven with nothing pending");
    // The data bus is driven only after a matching board select or DMA acknowledge.
    bus_select_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL2]
        $rose(isa_sd_oe) |-> $past(ior_l) && $past(sel || adc_ack))
        else $error("data bus driven without select");
    // Result DMA request follows a non-empty FIFO within one cycle, on the channel chosen then.
    adc_drq_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL13]
        !fifo_empty && q.ctrl[isa_daq_pkg::CTRL_ADC_DMA] |=> isa_drq[$past(ch_a)])
        else $error("result DMA request missing");
    // A word pushed into an empty FIFO reads back in the selected format.
    format_bit_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL20]
        adc_valid && fifo_empty && !fifo_flush
        |=> fifo_dout == ($past(adc_data) ^ {$past(q.ctrl[isa_daq_pkg::CTRL_BIPOLAR]), 15'h0000}))
        else $error("result format bit wrong");
    // The pending terminal count source holds until cleared.
    pend_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // [RL10]
        q.pend[isa_daq_pkg::SRC_TC] && !(q.wr_pend && !iow_l) |=> q.pend[isa_daq_pkg::SRC_TC])
        else $error("pending source lost without clear");
    // A mapped access answers with a 16-bit width claim one cycle on.
    width_answer_a: assert property (@(posedge sys_clk) disable iff (reset) any_hit |=> isa_cs16_oe && !isa_cs16_n) // [RL6]
        else $error("width answer missing");
endmodule : isa_daq_host_if

// File: verification/host_bus_model.sv
// Host channel bus master and DMA controller model for the acquisition adapter.
`timescale 1ns/100ps
module host_bus_model (
    input wire logic sys_clk,
    output logic [9:0] isa_sa,
    output logic [15:0] isa_sd_in,
    input wire logic [15:0] isa_sd_out,
    input wire logic isa_sd_oe,
    output logic isa_aen,
    output logic isa_ior_n,
    output logic isa_iow_n,
    output logic isa_tc,
    output logic [7:0] isa_dack_n
);
    logic [15:0] host_data;
    // The board's value wins while it drives; a released host leaves the inverse of its last word.
    assign isa_sd_in = isa_sd_oe ? isa_sd_out : host_data;
    initial begin
        isa_sa = 10'h000;
        host_data = 16'h0000;
        isa_aen = 1'b0;
        isa_ior_n = 1'b1;
        isa_iow_n = 1'b1;
        isa_tc = 1'b0;
        isa_dack_n = 8'hFF;
    end
    // Every access is a full 16-bit cycle, the width of all board registers.
    // Strobes stay low seven cycles and the bus holds six more, so the synchronised pins settle.
    task automatic cycle(input logic [9:0] a, input logic w, input logic [15:0] d, input logic aen,
                         input logic [7:0] dk, input logic tc, output logic [15:0] rdata, output logic oe);
        @(posedge sys_clk);
        isa_sa <= a;
        isa_aen <= aen;
        isa_dack_n <= dk;
        isa_tc <= tc;
        host_data <= d;
        if (w) isa_iow_n <= 1'b0;
        else isa_ior_n <= 1'b0;
        repeat (7) @(posedge sys_clk);
        #1;
        rdata = isa_sd_out;
        oe = isa_sd_oe;
        isa_ior_n <= 1'b1;
        isa_iow_n <= 1'b1;
        repeat (6) @(posedge sys_clk);
        isa_sa <= 10'h000;
        isa_aen <= 1'b0;
        isa_dack_n <= 8'hFF;
        isa_tc <= 1'b0;
        host_data <= ~d;
        // Step off the edge so callers look at registered answers after they settle.
        #1;
    endtask : cycle
endmodule : host_bus_model

// File: verification/tb_top.sv
// Self-checking testbench for the host channel interface.
`timescale 1ns/100ps
module tb_top;
    localparam logic [9:0] BASE = isa_daq_pkg::BASE_DEFAULT;
    logic sys_clk, reset, isa_aen, isa_ior_n, isa_iow_n, isa_tc, isa_sd_oe, isa_cs16_n, isa_cs16_oe;
    logic isa_chrdy, isa_chrdy_oe, adc_valid, acq_done, dac_fifo_need, dac_done, dac_update, dac_wr;
    logic [9:0] isa_sa;
    logic [15:0] isa_sd_in, isa_sd_out, adc_data, dac_wdata, rd_data, last_dac;
    logic [7:0] isa_dack_n, isa_drq, irq_req, irq_oe;
    logic rd_oe, claim;
    int errors = 0, check_count = 0, cycles = 0, dac_cnt = 0;

    isa_daq_host_if isa_daq_host_if_inst (.sys_clk, .reset, .isa_sa, .isa_sd_in, .isa_sd_out, .isa_sd_oe,
        .isa_aen, .isa_ior_n, .isa_iow_n, .isa_tc, .isa_dack_n, .isa_drq, .isa_cs16_n, .isa_cs16_oe,
        .isa_chrdy, .isa_chrdy_oe, .irq_req, .irq_oe, .adc_valid, .adc_data, .acq_done,
        .dac_fifo_need, .dac_done, .dac_update, .dac_wr, .dac_wdata);
    host_bus_model host_bus_model_inst (.sys_clk, .isa_sa, .isa_sd_in, .isa_sd_out, .isa_sd_oe,
        .isa_aen, .isa_ior_n, .isa_iow_n, .isa_tc, .isa_dack_n);

    // The clock runs at 10 MHz.
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Watch the width claim and ready answer, the waveform writes and the run time.
    always @(posedge sys_clk) begin
        if (isa_cs16_oe && isa_cs16_n === 1'b0 && isa_chrdy_oe && isa_chrdy === 1'b1) claim <= 1'b1;
        if (dac_wr === 1'b1) begin
            last_dac <= dac_wdata;
            dac_cnt <= dac_cnt + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            final_report();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input logic [9:0] a, input logic w, input logic [15:0] d, input logic aen,
                       input logic [7:0] dk, input logic tc);
        host_bus_model_inst.cycle(a, w, d, aen, dk, tc, rd_data, rd_oe);
    endtask : cyc
    task automatic wr(input logic [4:0] ofs, input logic [15:0] v);
        cyc({BASE[9:5], ofs}, 1'b1, v, 1'b0, 8'hFF, 1'b0);
    endtask : wr
    task automatic rd(input logic [4:0] ofs, input logic [15:0] mask);
        cyc({BASE[9:5], ofs}, 1'b0, 16'h0000, 1'b0, 8'hFF, 1'b0);
        rd_data = rd_data & mask;
    endtask : rd
    // Pushes n results back to back, counting up from a start value.
    task automatic push(input int n, input logic [15:0] start);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            adc_valid <= 1'b1;
            adc_data <= start + 16'(i);
        end
        @(posedge sys_clk);
        adc_valid <= 1'b0;
    endtask : push

    task automatic t_reset();
        rd(isa_daq_pkg::OFS_CTRL, 16'hFFFF);
        check(rd_data, 16'h0000);
        rd(isa_daq_pkg::OFS_DMA, 16'hFFFF);
        check(rd_data, 16'h0065);
        rd(isa_daq_pkg::OFS_STATUS, 16'h0700);
        check(rd_data, 16'h0100);
        check({isa_drq, irq_oe}, 16'h0000);
    endtask : t_reset

    // Only the board's upper address lines and a cleared DMA flag select it.
    task automatic t_decode();
        claim = 1'b0;
        wr(isa_daq_pkg::OFS_CTRL, 16'h0700);
        check({15'h0, claim}, 16'h0001);
        claim = 1'b0;
        cyc(10'h244, 1'b1, 16'hFFFF, 1'b0, 8'hFF, 1'b0);
        cyc(10'h244, 1'b0, 16'h0000, 1'b0, 8'hFF, 1'b0);
        check({14'h0, rd_oe, claim}, 16'h0000);
        cyc({BASE[9:5], 5'h04}, 1'b1, 16'hFFFF, 1'b1, 8'hFF, 1'b0);
        rd(isa_daq_pkg::OFS_CTRL, 16'hFFFF);
        check(rd_data, 16'h0700);
        rd(5'h0A, 16'hFFFF);
        check(rd_data, 16'h0000);
        wr(isa_daq_pkg::OFS_CTRL, 16'h0000);
    endtask : t_decode

    task automatic t_fifo();
        push(3, 16'hFFFE);
        for (int i = 0; i < 3; i++) begin
            rd(isa_daq_pkg::OFS_FIFO, 16'hFFFF);
            check(rd_data, 16'hFFFE + 16'(i));
        end
        wr(isa_daq_pkg::OFS_CTRL, 16'h1000);
        push(512, 16'h7FFF);
        rd(isa_daq_pkg::OFS_STATUS, 16'h0700);
        check(rd_data, 16'h0200);
        push(1, 16'hAAAA);
        rd(isa_daq_pkg::OFS_STATUS, 16'h0702);
        check(rd_data, 16'h0602);
        // Bipolar results come out with the sign bit flipped; the late push must be absent.
        for (int i = 0; i < 512; i++) begin
            rd(isa_daq_pkg::OFS_FIFO, 16'hFFFF);
            check(rd_data, (16'h7FFF + 16'(i)) ^ 16'h8000);
        end
        rd(isa_daq_pkg::OFS_STATUS, 16'h0700);
        check(rd_data, 16'h0500);
        wr(isa_daq_pkg::OFS_CLEAR, 16'h00BF);
        rd(isa_daq_pkg::OFS_STATUS, 16'h073F);
        check(rd_data, 16'h0100);
        wr(isa_daq_pkg::OFS_CTRL, 16'h0000);
    endtask : t_fifo

    // The acquisition done, DAC done and update sources each latch, steer to every line in turn and clear alone.
    task automatic t_irq();
        int s;
        for (int k = 0; k < 3; k++) begin
            s = (k == 0) ? 1 : k + 3;
            @(posedge sys_clk);
            acq_done <= (s == 1);
            dac_done <= (s == 4);
            dac_update <= (s == 5);
            @(posedge sys_clk);
            {acq_done, dac_done, dac_update} <= 3'b000;
            rd(isa_daq_pkg::OFS_STATUS, 16'h003F);
            check(rd_data, 16'h0001 << s);
            check({8'h00, irq_oe}, 16'h0000);
            for (int l = 0; l < 8; l++) begin
                wr(isa_daq_pkg::OFS_CTRL, (16'(l) << 8) | (16'h0001 << s));
                check({irq_req, irq_oe}, {2{8'h01 << l}});
            end
            wr(isa_daq_pkg::OFS_CLEAR, 16'h0001 << s);
            check({8'h00, irq_oe}, 16'h0000);
        end
        wr(isa_daq_pkg::OFS_CTRL, 16'h0000);
    endtask : t_irq

    task automatic t_dma();
        wr(isa_daq_pkg::OFS_CTRL, 16'h2000);
        check({8'h00, isa_drq}, 16'h0000);
        push(1, 16'h1234);
        repeat (8) @(posedge sys_clk);
        check({8'h00, isa_drq}, 16'h0020);
        cyc(10'h000, 1'b0, 16'h0000, 1'b1, 8'hDF, 1'b1);
        check(rd_data, 16'h1234);
        rd(isa_daq_pkg::OFS_STATUS, 16'h0105);
        check(rd_data | {isa_drq, 8'h00}, 16'h0105);
        dac_fifo_need <= 1'b1;
        wr(isa_daq_pkg::OFS_CTRL, 16'h6800);
        check({8'h00, isa_drq}, 16'h0040);
        cyc(10'h000, 1'b1, 16'hBEEF, 1'b1, 8'hBF, 1'b0);
        check(last_dac, 16'hBEEF);
        check(16'(dac_cnt), 16'h0001);
        rd(isa_daq_pkg::OFS_STATUS, 16'h0008);
        check(rd_data, 16'h0008);
        wr(isa_daq_pkg::OFS_DMA, 16'h0007);
        check({8'h00, isa_drq}, 16'h0001);
        dac_fifo_need <= 1'b0;
    endtask : t_dma

    task automatic final_report();
        if (errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report

    // Reset is held for twelve cycles, then the scenarios run in turn.
    initial begin
        reset = 1'b1;
        claim = 1'b0;
        adc_valid = 1'b0;
        adc_data = 16'h0000;
        {acq_done, dac_fifo_need, dac_done, dac_update} = 4'h0;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        t_reset();
        t_decode();
        t_fifo();
        t_irq();
        t_dma();
        final_report();
    end
endmodule : tb_top
